// ===== hdl/registered_bus_transceiver.sv
// Registered bidirectional transceiver between an A bus and a B bus, in two halves.
// Assumes bus and control pins are asynchronous to core_clk; pads resolve the three-signal buses.
`timescale 1ns/1ps
`default_nettype none

module registered_bus_transceiver #(
    parameter int HALF_W     = xcvr_pkg::HALF_W,
    parameter int FIFO_DEPTH = xcvr_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic                         core_clk,
    input  wire logic                         rst_n,
    // A side bus pins
    input  wire logic [2*HALF_W-1:0]          a_side_bus_line_i,
    output logic      [2*HALF_W-1:0]          a_side_bus_line_o,
    output logic      [2*HALF_W-1:0]          a_side_bus_line_oe,
    // B side bus pins
    input  wire logic [2*HALF_W-1:0]          b_side_bus_line_i,
    output logic      [2*HALF_W-1:0]          b_side_bus_line_o,
    output logic      [2*HALF_W-1:0]          b_side_bus_line_oe,
    // Per-half controls
    input  wire logic [1:0]                   a_to_b_drive_enable,
    input  wire logic [1:0]                   b_to_a_drive_enable_n,
    input  wire logic [1:0]                   a_side_capture_clock,
    input  wire logic [1:0]                   b_side_capture_clock,
    input  wire logic [1:0]                   b_output_source_select,
    input  wire logic [1:0]                   a_output_source_select,
    // Status
    output logic      [2*HALF_W-1:0]          a_store_value,
    output logic      [2*HALF_W-1:0]          b_store_value,
    output logic      [7:0]                   drive_mode,
    // Capture record stream
    output logic                              cap_valid,
    input  wire logic                         cap_ready,
    output logic      [HALF_W+1:0]            cap_data,
    output logic                              cap_overflow,
    input  wire logic                         cap_overflow_clr
);
    localparam int BW   = 2 * HALF_W;
    localparam int CW   = 12;
    localparam int RW   = HALF_W + 2;
    localparam int NEV  = xcvr_pkg::EVENTS;

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    logic [CW-1:0] ctrl_meta_q;
    logic [CW-1:0] ctrl_sync_q;
    logic [BW-1:0] a_meta_q;
    logic [BW-1:0] a_sync_q;
    logic [BW-1:0] b_meta_q;
    logic [BW-1:0] b_sync_q;
    logic [1:0]    a_cap_prev_q;
    logic [1:0]    b_cap_prev_q;

    wire [CW-1:0] ctrl_pins = {a_to_b_drive_enable, b_to_a_drive_enable_n,
                               a_side_capture_clock, b_side_capture_clock,
                               b_output_source_select, a_output_source_select};

    // Bus pins sampled every cycle, driven or not
    // No reset: at release the chain holds true pin levels, so a reset-low
    // copy of the active-low enable cannot drive A for a cycle
    always_ff @(posedge core_clk) begin
        ctrl_meta_q <= ctrl_pins;
        ctrl_sync_q <= ctrl_meta_q;
        a_meta_q    <= a_side_bus_line_i;
        a_sync_q    <= a_meta_q;
        b_meta_q    <= b_side_bus_line_i;
        b_sync_q    <= b_meta_q;
    end

    wire [1:0] ab_en_s   = ctrl_sync_q[11:10];
    wire [1:0] ba_en_n_s = ctrl_sync_q[9:8];
    wire [1:0] a_cap_s   = ctrl_sync_q[7:6];
    wire [1:0] b_cap_s   = ctrl_sync_q[5:4];
    wire [1:0] sel_b_s   = ctrl_sync_q[3:2];
    wire [1:0] sel_a_s   = ctrl_sync_q[1:0];

    // Reset holds the edge history high so a clock idling high is no edge
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            a_cap_prev_q <= 2'h3;
            b_cap_prev_q <= 2'h3;
        end else begin
            a_cap_prev_q <= a_cap_s;
            b_cap_prev_q <= b_cap_s;
        end
    end

    wire [1:0] a_cap_rise = a_cap_s & ~a_cap_prev_q;
    wire [1:0] b_cap_rise = b_cap_s & ~b_cap_prev_q;

    // ==========================================================
    // Per-half datapath
    // ==========================================================
    logic [BW-1:0]  a_store_q;
    logic [BW-1:0]  b_store_q;
    logic [BW-1:0]  a_out_q;
    logic [BW-1:0]  b_out_q;
    logic [1:0]     a_drv_q;
    logic [1:0]     b_drv_q;
    logic [7:0]     mode_q;

    genvar h;
    generate
        for (h = 0; h < 2; h++) begin : g_half
            logic [HALF_W-1:0]     a_live;
            logic [HALF_W-1:0]     b_live;
            logic [HALF_W-1:0]     a_out_d;
            logic [HALF_W-1:0]     b_out_d;
            logic                  a_drv_d;
            logic                  b_drv_d;
            xcvr_pkg::drive_mode_e mode_d;

            assign a_live = a_sync_q[h*HALF_W +: HALF_W];
            assign b_live = b_sync_q[h*HALF_W +: HALF_W];

            // A driven while its enable is low, B while its enable is high
            assign a_drv_d = !ba_en_n_s[h];
            assign b_drv_d = ab_en_s[h];

            // A output: live B or stored B
            assign a_out_d = sel_a_s[h] ? b_store_q[h*HALF_W +: HALF_W] : b_live;
            // B output: live A or stored A
            assign b_out_d = sel_b_s[h] ? a_store_q[h*HALF_W +: HALF_W] : a_live;

            assign mode_d = (a_drv_d && b_drv_d) ? xcvr_pkg::MODE_BOTH :
                            a_drv_d              ? xcvr_pkg::MODE_A_OUT :
                            b_drv_d              ? xcvr_pkg::MODE_B_OUT :
                                                   xcvr_pkg::MODE_ISOLATE;

            // Stores load only on a capture rise, else hold
            always_ff @(posedge core_clk) begin
                if (!rst_n) begin
                    a_store_q[h*HALF_W +: HALF_W] <= xcvr_pkg::STORE_RESET;
                    b_store_q[h*HALF_W +: HALF_W] <= xcvr_pkg::STORE_RESET;
                end else begin
                    if (a_cap_rise[h]) begin
                        a_store_q[h*HALF_W +: HALF_W] <= a_live;
                    end
                    // Driven B value captured too, copying A into both
                    if (b_cap_rise[h]) begin
                        b_store_q[h*HALF_W +: HALF_W] <= b_live;
                    end
                end
            end

            // Outputs from flip-flops so select changes cannot glitch
            always_ff @(posedge core_clk) begin
                if (!rst_n) begin
                    a_out_q[h*HALF_W +: HALF_W] <= xcvr_pkg::OUT_RESET;
                    b_out_q[h*HALF_W +: HALF_W] <= xcvr_pkg::OUT_RESET;
                    a_drv_q[h]                  <= 1'b0;
                    b_drv_q[h]                  <= 1'b0;
                    mode_q[h*4 +: 4]            <= xcvr_pkg::MODE_ISOLATE;
                end else begin
                    a_out_q[h*HALF_W +: HALF_W] <= a_out_d;
                    b_out_q[h*HALF_W +: HALF_W] <= b_out_d;
                    a_drv_q[h]                  <= a_drv_d;
                    b_drv_q[h]                  <= b_drv_d;
                    mode_q[h*4 +: 4]            <= mode_d;
                end
            end

            // Both live and enabled: outputs echo inputs, bus holds level
            assign a_side_bus_line_oe[h*HALF_W +: HALF_W] = {HALF_W{a_drv_q[h]}};
            assign b_side_bus_line_oe[h*HALF_W +: HALF_W] = {HALF_W{b_drv_q[h]}};
        end
    endgenerate

    assign a_side_bus_line_o = a_out_q;
    assign b_side_bus_line_o = b_out_q;
    assign a_store_value     = a_store_q;
    assign b_store_value     = b_store_q;
    assign drive_mode        = mode_q;

    // ==========================================================
    // Capture event log
    // ==========================================================
    // Event order: 0 = half0 A, 1 = half0 B, 2 = half1 A, 3 = half1 B.
    // Simultaneous rises with a select high are legal here but may
    // store a stale driven value, as the controller is told to stagger
    logic [NEV-1:0] pend_q;
    logic [NEV-1:0] pend_d;
    logic           ovf_q;
    logic [NEV-1:0] grant;
    logic [RW-1:0]  rec_d;

    wire [NEV-1:0] ev_rise = {b_cap_rise[1], a_cap_rise[1], b_cap_rise[0], a_cap_rise[0]};

    rec_stream_if #(.W(RW)) rec_if ();

    // Lowest pending event wins the single push slot
    always_comb begin
        grant = '0;
        for (int i = NEV - 1; i >= 0; i--) begin
            if (pend_q[i]) begin
                grant    = '0;
                grant[i] = 1'b1;
            end
        end
    end

    always_comb begin
        rec_d = '0;
        for (int i = 0; i < NEV; i++) begin
            if (grant[i]) begin
                rec_d[RW-1]   = 1'(i / 2);
                rec_d[RW-2]   = 1'(i % 2);
                rec_d[HALF_W-1:0] = (i % 2 == 1) ? b_store_q[(i/2)*HALF_W +: HALF_W]
                                                 : a_store_q[(i/2)*HALF_W +: HALF_W];
            end
        end
    end

    wire            pushed    = rec_if.valid && rec_if.ready;
    wire [NEV-1:0]  pop_mask  = pushed ? grant : '0;
    wire            lost      = |(ev_rise & pend_q & ~pop_mask);

    assign rec_if.valid = |pend_q;
    assign rec_if.data  = rec_d;

    // New rise sets pending even when the old one leaves this cycle
    assign pend_d = (pend_q & ~pop_mask) | ev_rise;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pend_q <= '0;
            ovf_q  <= 1'b0;
        end else begin
            pend_q <= pend_d;
            // Set wins over clear
            if (lost) begin
                ovf_q <= 1'b1;
            end else if (cap_overflow_clr) begin
                ovf_q <= 1'b0;
            end
        end
    end

    assign cap_overflow = ovf_q;

    rec_fifo #(
        .W     (RW),
        .DEPTH (FIFO_DEPTH)
    ) u_rec_fifo (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .push      (rec_if),
        .out_valid (cap_valid),
        .out_ready (cap_ready),
        .out_data  (cap_data)
    );

endmodule : registered_bus_transceiver

`default_nettype wire

// ===== hdl/xcvr_pkg.sv
// Constants, enumerations and record layout for the registered bus transceiver.
// Assumes a single core clock; all bus and control pins arrive asynchronously.
//
// Notes on behaviour
// - Two independent 8-bit halves with own controls, usable together as 16 bits.
// - Source select low passes live bus data, high passes stored register.
// - Changing a source select never glitches the driven bus outputs.
// - Capture clock rising edge loads its bus into its register, regardless.
// - Bus pins always sampled, even while this device drives them.
// - A-to-B enable active high, B-to-A active low; low/high isolates both.
// - Both enables low, A select low: A bus driven with live B.
// - Both enables low, A select high: A bus driven from B register.
// - Both enables high, B select low: B bus driven with live A.
// - Both enables high, B select high: B bus driven from A register.
// - A-to-B high, B-to-A low, both selects high: cross-drive both stored.
// - Driving B from A then capturing B copies A data into both.
// - Both directions live and enabled: each bus reinforces its last level.
package xcvr_pkg;

    // ==========================================================
    // Widths
    localparam int HALF_W     = 8;
    localparam int HALVES     = 2;
    localparam int BUS_W      = HALF_W * HALVES;
    localparam int SYNC_DEPTH = 2;

    // ==========================================================
    // Capture record: {half, side, data}
    localparam int REC_HALF_POS = HALF_W + 1;
    localparam int REC_SIDE_POS = HALF_W;
    localparam int REC_W        = HALF_W + 2;
    localparam int FIFO_DEPTH   = 16;
    localparam int EVENTS       = 2 * HALVES;

    // ==========================================================
    // Reset values
    localparam logic [HALF_W-1:0] STORE_RESET = 8'h00;
    localparam logic [HALF_W-1:0] OUT_RESET   = 8'h00;

    // ==========================================================
    // Drive mode of one half
    typedef enum logic [3:0] {
        MODE_ISOLATE = 4'b0001,
        MODE_A_OUT   = 4'b0010,
        MODE_B_OUT   = 4'b0100,
        MODE_BOTH    = 4'b1000
    } drive_mode_e;

endpackage : xcvr_pkg

// ===== hdl/rec_stream_if.sv
// Valid/ready carrier for capture records between transceiver core and its FIFO.
// Assumes both ends share one clock.
`timescale 1ns/1ps
`default_nettype none

interface rec_stream_if #(parameter int W = 10);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : rec_stream_if

`default_nettype wire

// ===== hdl/rec_fifo.sv
// Synchronous FIFO with registered read data and valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none

module rec_fifo #(
    parameter int W     = 10,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    // Fill side
    rec_stream_if.snk         push,
    // Drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0]   count_q;
    logic          out_valid_q;
    logic [W-1:0]  out_data_q;

    wire full      = (count_q == (AW+1)'(DEPTH));
    wire empty     = (count_q == '0);
    wire do_push   = push.valid && !full;
    wire load_out  = !empty && (!out_valid_q || out_ready);

    assign push.ready = !full;
    assign out_valid  = out_valid_q;
    assign out_data   = out_data_q;

    always_ff @(posedge core_clk) begin
        if (do_push) begin
            mem[wr_ptr_q] <= push.data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wr_ptr_q    <= '0;
            rd_ptr_q    <= '0;
            count_q     <= '0;
            out_valid_q <= 1'b0;
            out_data_q  <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_q <= wr_ptr_q + AW'(1);
            end
            if (load_out) begin
                out_data_q <= mem[rd_ptr_q];
                rd_ptr_q   <= rd_ptr_q + AW'(1);
            end
            if (load_out) begin
                out_valid_q <= 1'b1;
            end else if (out_ready) begin
                out_valid_q <= 1'b0;
            end
            count_q <= count_q + (AW+1)'(do_push) - (AW+1)'(load_out);
        end
    end

endmodule : rec_fifo

`default_nettype wire

// ===== sim/registered_bus_transceiver_chk.sv
// Port-level assertions for the registered bus transceiver.
// Assumes inputs change away from the rising edge of core_clk.
`timescale 1ns/1ps
`default_nettype none

module xcvr_chk (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        rst_n,
    // Bus pins
    input wire logic [15:0] a_side_bus_line_i,
    input wire logic [15:0] a_side_bus_line_o,
    input wire logic [15:0] a_side_bus_line_oe,
    input wire logic [15:0] b_side_bus_line_i,
    input wire logic [15:0] b_side_bus_line_o,
    input wire logic [15:0] b_side_bus_line_oe,
    // Controls
    input wire logic [1:0]  a_to_b_drive_enable,
    input wire logic [1:0]  b_to_a_drive_enable_n,
    input wire logic [1:0]  a_side_capture_clock,
    input wire logic [1:0]  b_output_source_select,
    input wire logic [1:0]  a_output_source_select,
    // Status
    input wire logic [15:0] a_store_value,
    input wire logic [15:0] b_store_value,
    input wire logic [7:0]  drive_mode,
    input wire logic        cap_valid,
    input wire logic        cap_ready,
    input wire logic        cap_overflow
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // ==========================================================
    // Properties
    property p_rst;
        disable iff (1'b0) !rst_n |=> a_side_bus_line_oe == 16'h0000
            && b_side_bus_line_oe == 16'h0000 && a_store_value == 16'h0000
            && b_store_value == 16'h0000
            && drive_mode == 8'h11;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    property p_b_on;
        a_to_b_drive_enable[0] [*5] |-> b_side_bus_line_oe[7:0] == 8'hff;
    endproperty
    a_b_on: assert property (p_b_on) else $error("b not driven");
    property p_b_off;
        !a_to_b_drive_enable[1] [*5] |-> b_side_bus_line_oe[15:8] == 8'h00;
    endproperty
    a_b_off: assert property (p_b_off) else $error("b driven");
    property p_a_on;
        !b_to_a_drive_enable_n[0] [*5] |-> a_side_bus_line_oe[7:0] == 8'hff;
    endproperty
    a_a_on: assert property (p_a_on) else $error("a not driven");
    property p_live_b;
        (a_to_b_drive_enable[0] && !b_output_source_select[0]
            && $stable(a_side_bus_line_i[7:0])) [*6]
            |-> b_side_bus_line_o[7:0] == a_side_bus_line_i[7:0];
    endproperty
    a_live_b: assert property (p_live_b) else $error("b live wrong");
    property p_live_a;
        (!b_to_a_drive_enable_n[0] && !a_output_source_select[0]
            && $stable(b_side_bus_line_i[7:0])) [*6]
            |-> a_side_bus_line_o[7:0] == b_side_bus_line_i[7:0];
    endproperty
    a_live_a: assert property (p_live_a) else $error("a live wrong");
    property p_sto_b;
        (a_to_b_drive_enable[0] && b_output_source_select[0]
            && $stable(a_store_value[7:0])) [*6]
            |-> b_side_bus_line_o[7:0] == a_store_value[7:0];
    endproperty
    a_sto_b: assert property (p_sto_b) else $error("b stored wrong");
    property p_sto_a;
        (!b_to_a_drive_enable_n[1] && a_output_source_select[1]
            && $stable(b_store_value[15:8])) [*6]
            |-> a_side_bus_line_o[15:8] == b_store_value[15:8];
    endproperty
    a_sto_a: assert property (p_sto_a) else $error("a stored wrong");
    property p_hold;
        !a_side_capture_clock[0] [*6] |-> $stable(a_store_value[7:0]);
    endproperty
    a_hold: assert property (p_hold) else $error("store changed");
    property p_cap;
        !a_side_capture_clock[1] ##1 a_side_capture_clock[1]
            |-> ##4 a_store_value[15:8] == $past(a_side_bus_line_i[15:8], 4);
    endproperty
    a_cap: assert property (p_cap) else $error("capture wrong");
    property p_both;
        (a_to_b_drive_enable[0] && !b_to_a_drive_enable_n[0]) [*5]
            |-> drive_mode[3:0] == 4'h8;
    endproperty
    a_both: assert property (p_both) else $error("mode wrong");

    c_pop: cover property (cap_valid && cap_ready);
    c_cross: cover property (drive_mode == 8'h88);
    c_ovf: cover property (cap_overflow);
endmodule : xcvr_chk

bind registered_bus_transceiver xcvr_chk u_chk (.*);

`default_nettype wire

// ===== sim/bus_partner.sv
// Other drivers on the A and B buses, with wire resolution.
// Assumes the bench never lets both parties drive one bit for long.
`timescale 1ns/1ps
`default_nettype none

module bus_partner (
    // Clock
    input  wire logic        core_clk,
    // Device drive
    input  wire logic [15:0] a_oe,
    input  wire logic [15:0] a_o,
    input  wire logic [15:0] b_oe,
    input  wire logic [15:0] b_o,
    // Other drivers
    input  wire logic [15:0] a_en,
    input  wire logic [15:0] a_val,
    input  wire logic [15:0] b_en,
    input  wire logic [15:0] b_val,
    // Resolved levels
    output logic      [15:0] a_bus,
    output logic      [15:0] b_bus
);
    logic [15:0] a_last_q = 16'h0000;
    logic [15:0] b_last_q = 16'h0000;
    wire  [15:0] a_drv    = a_oe | a_en;
    wire  [15:0] b_drv    = b_oe | b_en;

    // Undriven bits show the inverse of their last driven level
    assign a_bus = (a_oe & a_o) | (~a_oe & a_en & a_val) | (~a_drv & ~a_last_q);
    assign b_bus = (b_oe & b_o) | (~b_oe & b_en & b_val) | (~b_drv & ~b_last_q);

    always_ff @(posedge core_clk) begin
        a_last_q <= (a_drv & a_bus) | (~a_drv & a_last_q);
        b_last_q <= (b_drv & b_bus) | (~b_drv & b_last_q);
    end
endmodule : bus_partner

`default_nettype wire

// ===== sim/test_registered_bus_transceiver.sv
// Self-checking bench for the registered bus transceiver.
// Assumes the checker is bound in and bus_partner resolves the buses.
`timescale 1ns/1ps
`default_nettype none

module test_registered_bus_transceiver;
    logic        core_clk = 1'b0;
    logic        rst_n    = 1'b0;
    logic [15:0] a_bus, b_bus, a_o, a_oe, b_o, b_oe, a_st, b_st;
    logic [15:0] aen = 16'h0000, aval = 16'h0000, ben = 16'h0000, bval = 16'h0000;
    logic [1:0]  ab = 2'h0, ban = 2'h3, acap = 2'h0, bcap = 2'h0;
    logic [1:0]  bsel = 2'h0, asel = 2'h0;
    logic [7:0]  mode;
    logic [9:0]  cd;
    logic        cv, co, cr = 1'b0, cclr = 1'b0;
    int          fail_count = 0, comparisons = 0, n;

    registered_bus_transceiver u_dut (
        .core_clk(core_clk), .rst_n(rst_n),
        .a_side_bus_line_i(a_bus), .a_side_bus_line_o(a_o), .a_side_bus_line_oe(a_oe),
        .b_side_bus_line_i(b_bus), .b_side_bus_line_o(b_o), .b_side_bus_line_oe(b_oe),
        .a_to_b_drive_enable(ab), .b_to_a_drive_enable_n(ban),
        .a_side_capture_clock(acap), .b_side_capture_clock(bcap),
        .b_output_source_select(bsel), .a_output_source_select(asel),
        .a_store_value(a_st), .b_store_value(b_st), .drive_mode(mode),
        .cap_valid(cv), .cap_ready(cr), .cap_data(cd),
        .cap_overflow(co), .cap_overflow_clr(cclr));

    bus_partner u_partner (
        .core_clk(core_clk), .a_oe(a_oe), .a_o(a_o), .b_oe(b_oe), .b_o(b_o),
        .a_en(aen), .a_val(aval), .b_en(ben), .b_val(bval),
        .a_bus(a_bus), .b_bus(b_bus));

    initial forever #20 core_clk = ~core_clk;

    // ==========================================================
    // Helpers
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int k);
        repeat (k) @(negedge core_clk);
    endtask : tick
    task automatic cap(input logic [1:0] ha, input logic [1:0] hb);
        acap = ha;
        bcap = hb;
        tick(3);
        acap = 2'h0;
        bcap = 2'h0;
        tick(4);
    endtask : cap
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : close_out

    // ==========================================================
    // Scenarios
    task automatic t_reset;
        chk(a_oe, 16'h0000);
        chk(b_oe, 16'h0000);
        chk(a_st | b_st, 16'h0000);
        chk({8'h00, mode}, 16'h0011);
    endtask : t_reset
    task automatic t_fifo;
        aen = 16'hffff;
        for (int i = 1; i <= 20; i++) begin
            aval = 16'(i);
            cap(2'h1, 2'h0);
        end
        chk({15'h0000, co}, 16'h0001);
        chk({6'h00, cd}, 16'h0001);
        cclr = 1'b1;
        tick(3);
        cclr = 1'b0;
        tick(2);
        chk({15'h0000, co}, 16'h0000);
        n = 0;
        for (int k = 0; k < 60; k++) begin
            cr = ~cr;
            if (cv && cr) n++;
            tick(1);
        end
        cr = 1'b1;
        // Sixteen in memory, one in the output stage, one pending
        chk(16'(n), 16'h0012);
        chk({15'h0000, cv}, 16'h0000);
    endtask : t_fifo
    task automatic t_live_ab;
        aval = 16'h5aa5;
        ab = 2'h3;
        tick(6);
        chk(b_oe, 16'hffff);
        chk(b_o, 16'h5aa5);
        chk(a_oe, 16'h0000);
        chk({8'h00, mode}, 16'h0044);
        aval = 16'h3cc3;
        tick(6);
        chk(b_o, 16'h3cc3);
        ab = 2'h1;
        tick(6);
        chk(b_oe, 16'h00ff);
    endtask : t_live_ab
    task automatic t_store_ab;
        aval = 16'h1234;
        cap(2'h3, 2'h0);
        chk(a_st, 16'h1234);
        aval = 16'h9876;
        tick(8);
        chk(a_st, 16'h1234);
        ab = 2'h3;
        bsel = 2'h3;
        tick(6);
        chk(b_o, 16'h1234);
        bsel = 2'h1;
        tick(6);
        chk(b_o, 16'h9834);
    endtask : t_store_ab
    task automatic t_store_ba;
        ab = 2'h0;
        ban = 2'h0;
        bsel = 2'h0;
        aen = 16'h0000;
        ben = 16'hffff;
        bval = 16'hc3d4;
        tick(8);
        chk(a_oe, 16'hffff);
        chk(a_o, 16'hc3d4);
        chk(b_oe, 16'h0000);
        chk({8'h00, mode}, 16'h0022);
        cap(2'h0, 2'h3);
        chk(b_st, 16'hc3d4);
        bval = 16'h0f0f;
        asel = 2'h3;
        tick(6);
        chk(a_o, 16'hc3d4);
    endtask : t_store_ba
    task automatic t_cross;
        ab = 2'h3;
        bsel = 2'h3;
        ben = 16'h0000;
        tick(6);
        chk(a_o, 16'hc3d4);
        chk(b_o, 16'h1234);
        chk(a_oe & b_oe, 16'hffff);
        chk({8'h00, mode}, 16'h0088);
    endtask : t_cross
    task automatic t_copy;
        ban = 2'h3;
        bsel = 2'h0;
        asel = 2'h0;
        aen = 16'hffff;
        aval = 16'h6e71;
        tick(6);
        cap(2'h0, 2'h3);
        chk(b_st, 16'h6e71);
    endtask : t_copy
    task automatic t_hold;
        aval = 16'h4b2d;
        tick(6);
        ban = 2'h0;
        tick(8);
        aen = 16'h0000;
        tick(8);
        chk(a_bus, 16'h4b2d);
        chk(b_bus, 16'h4b2d);
        chk({8'h00, mode}, 16'h0088);
    endtask : t_hold

    initial begin
        tick(5);
        rst_n = 1'b1;
        tick(2);
        t_reset();
        t_fifo();
        t_live_ab();
        t_store_ab();
        t_store_ba();
        t_cross();
        t_copy();
        t_hold();
        close_out();
    end

    initial begin
        #100000;
        fail_count++;
        $display("MISMATCH %0t watchdog expired", $time);
        close_out();
    end
endmodule : test_registered_bus_transceiver

`default_nettype wire
